// *** hdl/prtb_pkg.sv ***
// ************************************************************
// Shared constants and types for the modulator control block
// ************************************************************
package prtb_pkg;

    // ********************************************************
    // Sizes
    // ********************************************************
    localparam int CNT_W  = 10;     // Counter and compare width
    localparam int NCH    = 4;      // Number of modulator channels
    localparam int ADDR_W = 12;     // APB address width

    // ********************************************************
    // Register indices; the byte address is four times these
    // ********************************************************
    localparam logic [7:0] IDX_CNT_LO = 8'hD1;  // Reload shadow, low
    localparam logic [7:0] IDX_CNT_HI = 8'hD2;  // Reload shadow, high
    localparam logic [7:0] IDX_CMP0   = 8'hD3;  // Compare shadow 0
    localparam logic [7:0] IDX_CMP4   = 8'hD7;  // Compare high bits
    localparam logic [7:0] IDX_MAIN   = 8'hDA;  // Main control
    localparam logic [7:0] IDX_BRAKE  = 8'hDB;  // Brake control
    localparam logic [7:0] IDX_STATUS = 8'hDC;  // Live status

    // ********************************************************
    // Reset values and field positions
    // ********************************************************
    localparam logic [7:0]       MAIN_RST     = 8'h00;
    localparam logic [7:0]       BRAKE_RST    = 8'h00;
    localparam logic [7:0]       SHADOW_RST   = 8'h00;
    localparam logic [7:0]       MAIN_WMASK   = 8'hF6; // Bits 3, 0 unused
    localparam logic [NCH-1:0]   RAW_RST      = 4'hF;  // Channels start high
    localparam logic [CNT_W-1:0] CMP_ALL_ONES = 10'h3FF;
    localparam logic [CNT_W-1:0] CMP_ZERO     = 10'h000;
    localparam int               CMP_HI_W     = 2;     // Bits per channel
    localparam int               STAT_BRAKE   = 4;     // Status bit
    localparam int               HI_BITS_W    = 2;     // Reload high bits

    // Main control layout, bit 7 down to bit 0
    typedef struct packed {
        logic run;
        logic shadow_transfer_request;
        logic inv3;
        logic inv2;
        logic rsv3;
        logic inv1;
        logic inv0;
        logic rsv0;
    } prtb_main_t;

    // Brake control layout, bit 7 down to bit 0
    typedef struct packed {
        logic            stop_sel;
        logic            polarity;
        logic            pin_sel;
        logic            enable;
        logic [NCH-1:0]  level;
    } prtb_brake_t;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : reg_addr

endpackage : prtb_pkg

// *** hdl/prtb_counter.sv ***
`timescale 1ns/100ps
// ************************************************************
// Reload down counter with shadow transfer at underflow
// ************************************************************
module prtb_counter #(
    parameter int CNT_W = prtb_pkg::CNT_W
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             run,        // Count enable
    input  wire logic             shadow_transfer_request,       // Transfer pending
    input  wire logic [CNT_W-1:0] reload_sh,  // Reload shadow value
    output logic      [CNT_W-1:0] count,      // Live count
    output logic                  underflow,  // Pulse at count zero while running; high every running cycle if reload is 0
    output logic                  load        // Shadow copy pulse
);

    logic [CNT_W-1:0] count_r;   // Down counter
    logic [CNT_W-1:0] reload_r;  // Working reload value

    if (CNT_W != prtb_pkg::CNT_W)
        $error("prtb_counter: only the documented width is supported");

    // Underflow only while running, so a stopped counter never loads
    assign underflow = run & (count_r == '0);
    assign load      = underflow & shadow_transfer_request;                  // [R18]
    assign count     = count_r;

    // Count down, reloading at underflow; halts while run is low
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            count_r  <= '0;
            reload_r <= '0;
        end
        else if (underflow)
        begin
            // A fresh reload value takes effect in the same period
            count_r  <= load ? reload_sh : reload_r;      // [R18]
            reload_r <= load ? reload_sh : reload_r;
        end
        else if (run)                                     // [R4]
        begin
            count_r <= count_r - 1'b1;
        end
    end

endmodule : prtb_counter

// *** hdl/prtb_chan.sv ***
`timescale 1ns/100ps
// ************************************************************
// One modulator channel: working compare and raw level
// ************************************************************
module prtb_chan #(
    parameter int CNT_W = prtb_pkg::CNT_W
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             run,        // Counter running
    input  wire logic             underflow,  // Period start pulse
    input  wire logic             load,       // Shadow copy pulse
    input  wire logic [CNT_W-1:0] count,      // Live count
    input  wire logic [CNT_W-1:0] cmp_sh,     // Compare shadow
    output logic                  raw         // Non-inverted level
);

    logic [CNT_W-1:0] cmp_r;    // Working compare
    logic [CNT_W-1:0] cmp_eff;  // Compare that applies this period
    logic             raw_r;    // Level register, held when stopped

    if (CNT_W != prtb_pkg::CNT_W)
        $error("prtb_chan: only the documented width is supported");

    assign cmp_eff = load ? cmp_sh : cmp_r;
    assign raw     = raw_r;

    // High at underflow, low at the match; zero never matches so it
    // stays high, and all ones is forced low for the whole period
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cmp_r <= '0;
            raw_r <= 1'b1;
        end
        else
        begin
            if (load)
                cmp_r <= cmp_sh;                                 // [R18]
            if (underflow)
                raw_r <= (cmp_eff != prtb_pkg::CMP_ALL_ONES);    // [R20]
            else if (run && count == cmp_r &&
                     cmp_r != prtb_pkg::CMP_ZERO)
                raw_r <= 1'b0;                                   // [R20]
        end
    end

endmodule : prtb_chan

// *** hdl/prtb_ctrl.sv ***
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// R1 - Software presets compares to constant codes
// R2 - Then sets run with transfer, polls transfer
// R3 - Run cleared only after transfer completed
// R4 - Stopping holds each output's last level
// R5 - Brake-when-stopped only for time-critical stops
// R6 - Main control bit layout: run, transfer, inverts
// R7 - Invert bit swaps high and low phases
// R8 - Brake forces outputs to brake level bits
// R9 - Brake only when enabled; trigger selects
// R10 - Enabled, no selects: brake always on
// R11 - Stopped-select: brake while run is zero
// R12 - Pin-select: brake when pin matches polarity
// R13 - Pin-caused brake clears the run bit
// R14 - Software never sets both trigger selects
// R15 - Software polls run to see pin brake
// R16 - Brake release restores pre-brake output levels
// R17 - Software recipe for clean brake-to-run return
// R18 - Shadows copied only at underflow while running
// R19 - Hardware clears transfer when copy happens
// R20 - Underflow drives high until compare match
// R21 - Unused main control bits read zero
module prtb_ctrl #(
    parameter int CNT_W = prtb_pkg::CNT_W,
    parameter int NCH   = prtb_pkg::NCH
) (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [prtb_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        brake_input_pin,
    output logic      [NCH-1:0]              pwm_out,
    output logic                             brake_active
);

    // ********************************************************
    // Elaboration checks
    // ********************************************************
    if (CNT_W != prtb_pkg::CNT_W || NCH != prtb_pkg::NCH)
        $error("prtb_ctrl: register layout fixes width and channels");

    // ********************************************************
    // Declarations
    // ********************************************************
    prtb_pkg::prtb_main_t  main_r;     // Main control register
    prtb_pkg::prtb_main_t  main_nxt;   // Its next value
    prtb_pkg::prtb_brake_t brk_r;      // Brake control register
    logic [7:0]            sh_r [7];   // Reload and compare shadows
    logic [31:0]           prdata_r;   // Read data, loaded in setup
    logic                  pslverr_r;  // Error, loaded in setup
    logic [NCH-1:0]        pwm_out_r;  // Output level register
    logic                  brake_r;    // Brake state for status

    logic [7:0]            idx;        // Register index from address
    logic                  aligned;    // Address in the register page
    logic                  hit_sh;     // Shadow range hit
    logic [2:0]            sh_sel;     // Shadow slot
    logic                  hit_main;
    logic                  hit_brk;
    logic                  hit_stat;
    logic                  hit_any;    // Mapped address
    logic                  wr_en;      // Write takes effect this edge
    logic                  rd_setup;   // Setup phase of any access
    logic [7:0]            rd_mux;     // Selected register byte

    logic                  pin_match;  // Pin at the selected polarity
    logic                  pin_brake;  // Brake caused by the pin
    logic                  brake_trig; // Selected trigger condition
    logic                  brake_w;    // Brake asserted
    logic [NCH-1:0]        inv_w;      // Per-channel invert bits
    logic [NCH-1:0]        raw_w;      // Channel levels before invert
    logic [CNT_W-1:0]      count_w;
    logic                  underflow_w;
    logic                  shadow_transfer_request_load;  // Shadow copy this cycle

    // ********************************************************
    // APB decode; zero wait states
    // ********************************************************
    assign idx      = paddr[9:2];
    assign aligned  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign hit_sh   = aligned && idx >= prtb_pkg::IDX_CNT_LO &&
                      idx <= prtb_pkg::IDX_CMP4;
    assign sh_sel   = 3'(idx - prtb_pkg::IDX_CNT_LO);
    assign hit_main = paddr == prtb_pkg::reg_addr(prtb_pkg::IDX_MAIN);
    assign hit_brk  = paddr == prtb_pkg::reg_addr(prtb_pkg::IDX_BRAKE);
    assign hit_stat = paddr == prtb_pkg::reg_addr(prtb_pkg::IDX_STATUS);
    assign hit_any  = hit_sh | hit_main | hit_brk | hit_stat;
    // Status is read-only, so a write to it counts as an error
    assign wr_en    = psel & penable & pwrite & hit_any & ~hit_stat;
    assign rd_setup = psel & ~penable;

    // Read selection; reserved bits fold to zero through the mask
    assign rd_mux = hit_sh   ? sh_r[sh_sel] :
                    hit_main ? main_r & prtb_pkg::MAIN_WMASK :   // [R21]
                    hit_brk  ? brk_r :
                    hit_stat ? {3'b000, brake_r, pwm_out_r} :
                               8'h00;

    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // Read data and error are caught in setup so they are flops
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (rd_setup)
        begin
            prdata_r  <= {24'h00_0000, rd_mux};
            pslverr_r <= ~hit_any | (pwrite & hit_stat);
        end
    end

    // ********************************************************
    // Shadow and brake control registers
    // ********************************************************
    // Shadows only hold data; the counter and channels copy them at underflow
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 7; i++)
                sh_r[i] <= prtb_pkg::SHADOW_RST;
            brk_r <= prtb_pkg::BRAKE_RST;
        end
        else
        begin
            if (wr_en && hit_sh)
                sh_r[sh_sel] <= pwdata[7:0];
            if (wr_en && hit_brk)
                brk_r <= pwdata[7:0];
        end
    end

    // ********************************************************
    // Main control register
    // ********************************************************
    // A software write beats the hardware transfer clear, so a
    // fresh request made in the copy cycle is not lost. The pin
    // brake beats everything: run cannot be set while it holds.
    always_comb
    begin
        main_nxt = main_r;
        if (shadow_transfer_request_load)
            main_nxt.shadow_transfer_request = 1'b0;                                // [R19]
        if (wr_en && hit_main)
            main_nxt = pwdata[7:0] & prtb_pkg::MAIN_WMASK; // [R6] [R21]
        if (pin_brake)
            main_nxt.run = 1'b0;                                 // [R13]
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            main_r <= prtb_pkg::MAIN_RST;
        else
            main_r <= main_nxt;
    end

    assign inv_w = {main_r.inv3, main_r.inv2, main_r.inv1, main_r.inv0};

    // ********************************************************
    // Brake trigger selection
    // ********************************************************
    // If both selects are set (not allowed) the pin trigger wins
    assign pin_match  = (brake_input_pin == brk_r.polarity);     // [R12]
    assign pin_brake  = brk_r.enable & brk_r.pin_sel & pin_match;
    assign brake_trig = brk_r.pin_sel  ? pin_match :             // [R12]
                        brk_r.stop_sel ? ~main_r.run :           // [R11]
                                         1'b1;                   // [R10]
    assign brake_w    = brk_r.enable & brake_trig;               // [R9]

    // ********************************************************
    // Counter and channels
    // ********************************************************
    prtb_counter #(
        .CNT_W     (CNT_W)
    ) u_counter (
        .clock     (clock),
        .nrst      (nrst),
        .run       (main_r.run),
        .shadow_transfer_request      (main_r.shadow_transfer_request),
        .reload_sh ({sh_r[1][prtb_pkg::HI_BITS_W-1:0], sh_r[0]}),
        .count     (count_w),
        .underflow (underflow_w),
        .load      (shadow_transfer_request_load)
    );

    for (genvar n = 0; n < NCH; n++)
    begin : g_chan
        prtb_chan #(
            .CNT_W     (CNT_W)
        ) u_chan (
            .clock     (clock),
            .nrst      (nrst),
            .run       (main_r.run),
            .underflow (underflow_w),
            .load      (shadow_transfer_request_load),
            .count     (count_w),
            .cmp_sh    ({sh_r[6][prtb_pkg::CMP_HI_W*n +: 2], sh_r[2+n]}),
            .raw       (raw_w[n])
        );
    end

    // ********************************************************
    // Output stage
    // ********************************************************
    // Raw levels freeze while stopped, so leaving brake falls back
    // to exactly the level shown before brake came on
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_out_r <= prtb_pkg::RAW_RST;
            brake_r   <= 1'b0;
        end
        else
        begin
            pwm_out_r <= brake_w ? brk_r.level             // [R8]
                                 : raw_w ^ inv_w;          // [R7] [R16]
            brake_r   <= brake_w;
        end
    end

    assign pwm_out      = pwm_out_r;
    assign brake_active = brake_r;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    stopped_hold_a: assert property (
        !main_r.run |=> $stable(raw_w))                          // [R4]
        else $error("Channel level moved while stopped");
    invert_out_a: assert property (
        !brake_w |=> pwm_out == $past(raw_w ^ inv_w))            // [R7]
        else $error("Output does not follow invert setting");
    brake_force_a: assert property (
        brake_w |=> pwm_out == $past(brk_r.level))               // [R8]
        else $error("Brake did not force the brake levels");
    brake_gate_a: assert property (
        !brk_r.enable |-> !brake_w)                              // [R9]
        else $error("Brake asserted while disabled");
    always_brake_a: assert property (
        brk_r.enable && !brk_r.stop_sel && !brk_r.pin_sel
        |-> brake_w)                                             // [R10]
        else $error("Unconditional brake not asserted");
    stopped_brake_a: assert property (
        brk_r.enable && brk_r.stop_sel && !brk_r.pin_sel
        |-> brake_w == !main_r.run)                              // [R11]
        else $error("Stopped brake does not track run");
    pin_brake_a: assert property (
        brk_r.enable && brk_r.pin_sel
        |-> brake_w == (brake_input_pin == brk_r.polarity))      // [R12]
        else $error("Pin brake does not track the pin");
    pin_run_clear_a: assert property (
        pin_brake |=> !main_r.run)                               // [R13]
        else $error("Pin brake left run set");
    brake_release_a: assert property (
        brake_w ##1 (!brake_w && !main_r.run)
        |=> pwm_out == $past(raw_w ^ inv_w, 3))                  // [R16]
        else $error("Output did not return to its pre-brake level");
    no_copy_stopped_a: assert property (
        !main_r.run |-> !shadow_transfer_request_load)                              // [R18]
        else $error("Shadow copy while stopped");
    shadow_transfer_request_clear_a: assert property (
        shadow_transfer_request_load && !(wr_en && hit_main) |=> !main_r.shadow_transfer_request)      // [R19]
        else $error("Transfer bit not cleared after copy");
    rsv_zero_a: assert property (
        !main_r.rsv3 && !main_r.rsv0)                            // [R21]
        else $error("Unused control bits became set");

    pin_brake_c: cover property (pin_brake ##1 !main_r.run);
    transfer_c:  cover property (main_r.shadow_transfer_request ##[1:64] shadow_transfer_request_load);
    stop_brake_c: cover property (
        brk_r.stop_sel && main_r.run ##1 !main_r.run && brake_w);

endmodule : prtb_ctrl

// *** tb/prtb_stage_model.sv ***
`timescale 1ns/100ps
// ************************************************************
// Power stage and brake source beside the modulator outputs
// ************************************************************
module prtb_stage_model (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [3:0] pwm_out,    // Levels seen by the stage
    input  wire logic       fault,      // Bench asks for a brake
    input  wire logic       polarity,   // Active level of the pin
    output logic            brake_input_pin
);
    // Stage state as last seen, checked by the bench after release
    logic [3:0] seen_r;

    // Pin is a driven level; its idle level is the inverse of active
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            brake_input_pin <= ~polarity;
            seen_r          <= 4'hF;
        end
        else
        begin
            brake_input_pin <= fault ? polarity : ~polarity;
            seen_r          <= pwm_out;
        end
    end
endmodule : prtb_stage_model

// *** tb/tb.sv ***
`timescale 1ns/100ps
// ************************************************************
// Self-checking bench for the modulator control block
// ************************************************************
module tb;
    logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;         // APB byte address
    logic [31:0] pwdata, prdata;
    logic        pin, brake_active, fault, pol;
    logic [3:0]  pwm_out;
    logic [31:0] rd;            // Last read data
    logic        er;            // Last error flag
    int          miscompares, compares;
    int          hi_cnt;        // Cycles a channel was seen high

    prtb_ctrl i_dut (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .brake_input_pin(pin), .pwm_out(pwm_out),
        .brake_active(brake_active));

    prtb_stage_model i_stage (.clock(clock), .nrst(nrst),
        .pwm_out(pwm_out), .fault(fault), .polarity(pol),
        .brake_input_pin(pin));

    // ********************************************************
    // Tasks
    // ********************************************************
    // One APB transfer; waits for pready rather than assuming it
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Let a register change reach the registered outputs
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // ********************************************************
    // Clock, reset and watchdog
    // ********************************************************
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Whole run is a few hundred cycles; this is ample margin
    initial
    begin
        #(40 * 20000);
        miscompares++;
        report_and_stop();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        miscompares = 0;
        compares = 0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        fault = 1'b0;
        pol = 1'b1;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        #1;
        chk("pwm_reset", pwm_out, 4'hF);
        apb(1'b0, 8'hDA, 8'h00);
        chk("main_reset", rd, 32'h00000000);
        chk("main_err", er, 1'b0);
        apb(1'b0, 8'hDB, 8'h00);
        chk("brake_reset", rd, 32'h00000000);
        // Unused bits drop; inverts take effect while stopped
        apb(1'b1, 8'hDA, 8'h3F);
        apb(1'b0, 8'hDA, 8'h00);
        chk("main_mask", rd, 32'h00000036);
        settle();
        chk("pwm_inverted", pwm_out, 4'h0);
        apb(1'b1, 8'hDA, 8'h00);
        // Transfer without run never completes
        apb(1'b1, 8'hDA, 8'h40);
        repeat (10) @(posedge clock);
        apb(1'b0, 8'hDA, 8'h00);
        chk("shadow_transfer_request_stuck", rd, 32'h00000040);
        // Preset channel 0 to always low, then run with transfer
        apb(1'b1, 8'hD3, 8'hFF);
        apb(1'b1, 8'hD7, 8'h03);
        apb(1'b1, 8'hDA, 8'hC0);
        for (int i = 0; i < 20; i++)
        begin
            apb(1'b0, 8'hDA, 8'h00);
            if (rd[6] === 1'b0)
                break;
        end
        chk("shadow_transfer_request_cleared", rd, 32'h00000080);
        settle();
        chk("pwm_running", pwm_out, 4'hE);
        apb(1'b1, 8'hDA, 8'h00);
        repeat (10) @(posedge clock);
        #1;
        chk("pwm_held", pwm_out, 4'hE);
        // Brake always on, then released
        apb(1'b1, 8'hDB, 8'h1A);
        settle();
        chk("brake_always", pwm_out, 4'hA);
        chk("brake_flag", brake_active, 1'b1);
        apb(1'b0, 8'hDC, 8'h00);
        chk("status_brake", rd, 32'h0000001A);
        apb(1'b1, 8'hDB, 8'h0A);
        settle();
        chk("brake_off", pwm_out, 4'hE);
        chk("brake_flag_off", brake_active, 1'b0);
        // Brake while stopped follows the run bit
        apb(1'b1, 8'hDB, 8'h95);
        settle();
        chk("brake_stopped", pwm_out, 4'h5);
        apb(1'b1, 8'hDA, 8'h80);
        settle();
        chk("brake_run", pwm_out, 4'hE);
        apb(1'b1, 8'hDA, 8'h00);
        apb(1'b1, 8'hDB, 8'h00);
        // Pin brake, both polarities; never both selects set
        for (int p = 1; p >= 0; p--)
        begin
            pol <= p[0];
            fault <= 1'b0;
            settle();
            apb(1'b1, 8'hDB, {1'b0, p[0], 1'b1, 5'h1C});
            apb(1'b1, 8'hDA, 8'h80);
            settle();
            chk("pin_idle", pwm_out, 4'hE);
            fault <= 1'b1;
            settle();
            chk("pin_brake", pwm_out, 4'hC);
            apb(1'b0, 8'hDA, 8'h00);
            chk("run_cleared", rd, 32'h00000000);
            fault <= 1'b0;
            settle();
            chk("pin_release", pwm_out, 4'hE);
            chk("stage_seen", i_stage.seen_r, 4'hE);
            apb(1'b1, 8'hDB, 8'h00);
        end
        // Reload 4, channel 1 compare 2: high 3 of every 5 cycles
        apb(1'b1, 8'hD1, 8'h04);
        apb(1'b1, 8'hD4, 8'h02);
        apb(1'b1, 8'hDA, 8'hC0);
        settle();
        hi_cnt = 0;
        repeat (20)
        begin
            @(posedge clock);
            #1;
            if (pwm_out[1] === 1'b1)
                hi_cnt++;
        end
        chk("duty_high", hi_cnt, 32'd12);
        apb(1'b1, 8'hDA, 8'h00);
        // Unmapped word answers with an error and zero data
        apb(1'b0, 8'hE0, 8'h00);
        chk("unmapped_err", er, 1'b1);
        chk("unmapped_data", rd, 32'h00000000);
        // Status is read-only, so a write is refused
        apb(1'b1, 8'hDC, 8'h00);
        chk("status_wr_err", er, 1'b1);
        report_and_stop();
    end
endmodule : tb
